//--- ehl_defs.vh
`ifndef EHL_DEFS_VH
`define EHL_DEFS_VH

// Log depths
`define EHL_GEN_DEPTH_OLD 8'd20
`define EHL_GEN_DEPTH_NEW 8'd100
`define EHL_ETH_DEPTH 8'd64
`define EHL_GEN_MEM 100
`define EHL_ETH_MEM 64
`define EHL_GEN_AW 7
`define EHL_ETH_AW 6

// Record fields
`define EHL_STAT_W 16
`define EHL_NODE_W 8
`define EHL_TIME_W 32
`define EHL_GEN_W 56
`define EHL_ETH_W 64
`define EHL_NV_W 57
`define EHL_NV_VALID 56
`define EHL_EXC_W 64

// Operating-time step
`define EHL_STEP_S 64'd360
`define EHL_CLK_HZ 64'd200000000

`endif

//--- ehl_optime.v
`timescale 1ns/1ps
`default_nettype none
`include "ehl_defs.vh"

module ehl_optime #(
  parameter [63:0] TICK_CYC = `EHL_STEP_S * `EHL_CLK_HZ
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire run_i,
  input wire zero_i,
  output reg [31:0] time_o
);

  reg [36:0] pre;
  wire [36:0] pre_last = TICK_CYC[36:0] - 37'h1;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pre <= 37'h0;
      time_o <= 32'h0;
    end else if (zero_i) begin
      pre <= 37'h0;
      time_o <= 32'h0;
    end else if (run_i) begin
      if (pre >= pre_last) begin
        pre <= 37'h0;
        time_o <= time_o + 32'h1;
      end else begin
        pre <= pre + 37'h1;
      end
    end
  end

endmodule // ehl_optime

`default_nettype wire

//--- ehl_ring.v
`timescale 1ns/1ps
`default_nettype none

module ehl_ring #(
  parameter DW = 56,
  parameter DEPTH = 100,
  parameter AW = 7
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire clr_i,
  input wire [7:0] lim_i,
  input wire wr_i,
  input wire [DW-1:0] wr_data_i,
  input wire rd_i,
  input wire [6:0] rd_idx_i,
  output reg [DW-1:0] rd_data_o,
  output reg [7:0] cnt_o
);

  reg [DW-1:0] mem [0:DEPTH-1];
  reg [7:0] wptr;

  // Index 0 is the newest record
  function [7:0] ehl_slot;
    input [7:0] ptr;
    input [7:0] lim;
    input [6:0] idx;
    reg [7:0] s;
    begin
      s = ptr + lim - 8'h1 - {1'b0, idx};
      ehl_slot = (s >= lim) ? s - lim : s;
    end
  endfunction

  wire [7:0] base = clr_i ? 8'h0 : wptr;
  wire [7:0] wnext = (base + 8'h1 >= lim_i) ? 8'h0 : base + 8'h1;
  wire [7:0] rslot = ehl_slot(wptr, lim_i, rd_idx_i);

  always @(posedge clk_i) begin
    if (wr_i)
      mem[base[AW-1:0]] <= wr_data_i;
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wptr <= 8'h0;
      cnt_o <= 8'h0;
      rd_data_o <= {DW{1'b0}};
    end else begin
      if (wr_i) begin
        wptr <= wnext;
        if (clr_i)
          cnt_o <= 8'h1;
        else if (cnt_o < lim_i)
          cnt_o <= cnt_o + 8'h1;
      end else if (clr_i) begin
        wptr <= 8'h0;
        cnt_o <= 8'h0;
      end
      if (rd_i)
        rd_data_o <= ({1'b0, rd_idx_i} < cnt_o) ? mem[rslot[AW-1:0]] : {DW{1'b0}};
    end
  end

endmodule // ehl_ring

`default_nettype wire

//--- ehl_logger.v
`timescale 1ns/1ps
`default_nettype none
`include "ehl_defs.vh"

module ehl_logger #(
  parameter [63:0] TICK_CYC = `EHL_STEP_S * `EHL_CLK_HZ
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire supply_on_i,
  input wire variant_new_i,
  input wire err_i,
  input wire [15:0] err_status_i,
  input wire [7:0] err_node_i,
  input wire err_crit_i,
  input wire eth_err_i,
  input wire [15:0] eth_code_i,
  input wire [15:0] eth_detail_i,
  input wire clr_i,
  input wire ctl_reset_i,
  input wire rd_req_i,
  input wire rd_eth_i,
  input wire [6:0] rd_idx_i,
  output reg rd_valid_o,
  output reg [15:0] rd_status_o,
  output reg [15:0] rd_detail_o,
  output reg [63:0] rd_exc_detail_o,
  output reg [31:0] rd_time_o,
  output reg [7:0] rd_count_o,
  output reg nv_req_o,
  output reg nv_we_o,
  output reg [6:0] nv_addr_o,
  output reg [56:0] nv_wdata_o,
  input wire nv_ack_i,
  input wire [56:0] nv_rdata_i,
  output reg busy_o,
  output wire [31:0] op_time_o
);

  localparam [2:0] S_LOAD = 3'h0;
  localparam [2:0] S_LWAIT = 3'h1;
  localparam [2:0] S_PUT = 3'h2;
  localparam [2:0] S_IDLE = 3'h3;
  localparam [2:0] S_WWAIT = 3'h4;
  localparam [2:0] S_CISS = 3'h5;
  localparam [2:0] S_CWAIT = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  reg sup_m;
  reg sup_s;
  reg var_m;
  reg var_s;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sup_m <= 1'b0;
      sup_s <= 1'b0;
      var_m <= 1'b0;
      var_s <= 1'b0;
    end else begin
      sup_m <= supply_on_i;
      sup_s <= sup_m;
      var_m <= variant_new_i;
      var_s <= var_m;
    end
  end

  wire [7:0] gen_lim = var_s ? `EHL_GEN_DEPTH_NEW : `EHL_GEN_DEPTH_OLD;

  ////////////////////////////////////////////////////////////////////////////
  // Operating-time counter

  ehl_optime #(
    .TICK_CYC(TICK_CYC)
  ) u_optime (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(sup_s),
    .zero_i(ctl_reset_i),
    .time_o(op_time_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Restore, critical mirror and clear sequencer

  reg [2:0] state;
  reg [6:0] slot;
  reg [6:0] nv_ptr;
  reg [56:0] rest_rec;
  reg crit_pend;
  reg [55:0] crit_rec;
  reg clr_pend;

  wire last_slot = ({1'b0, slot} == gen_lim - 8'h1);
  wire [6:0] ptr_next = ({1'b0, nv_ptr} + 8'h1 >= gen_lim) ? 7'h0 : nv_ptr + 7'h1;
  wire put_ok = (state == S_PUT) && !clr_pend && !err_i;
  wire crit_take = (state == S_IDLE) && !clr_pend && crit_pend;
  wire new_crit = err_i && err_crit_i;

  // Live errors always win the RAM write port over restored records
  wire gen_wr = err_i || (put_ok && rest_rec[`EHL_NV_VALID]);
  wire [55:0] live_rec = {err_status_i, err_node_i, op_time_o};
  wire [55:0] gen_wdata = err_i ? live_rec : rest_rec[55:0];

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      crit_pend <= 1'b0;
      crit_rec <= 56'h0;
      clr_pend <= 1'b0;
    end else begin
      crit_pend <= new_crit || (crit_pend && !crit_take && !clr_i);
      if (new_crit)
        crit_rec <= live_rec;
      clr_pend <= clr_i || (clr_pend && !(state == S_LOAD || state == S_PUT ||
                  state == S_IDLE));
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= S_LOAD;
      slot <= 7'h0;
      nv_ptr <= 7'h0;
      rest_rec <= 57'h0;
      nv_req_o <= 1'b0;
      nv_we_o <= 1'b0;
      nv_addr_o <= 7'h0;
      nv_wdata_o <= 57'h0;
      busy_o <= 1'b1;
    end else begin
      case (state)
        S_LOAD: begin
          if (clr_pend) begin
            state <= S_CISS;
            slot <= 7'h0;
            nv_ptr <= 7'h0;
          end else begin
            nv_req_o <= 1'b1;
            nv_we_o <= 1'b0;
            nv_addr_o <= slot;
            state <= S_LWAIT;
          end
        end
        S_LWAIT: begin
          if (nv_ack_i) begin
            nv_req_o <= 1'b0;
            rest_rec <= nv_rdata_i;
            state <= S_PUT;
          end
        end
        S_PUT: begin
          if (clr_pend) begin
            state <= S_CISS;
            slot <= 7'h0;
            nv_ptr <= 7'h0;
          end else if (!err_i) begin
            if (rest_rec[`EHL_NV_VALID])
              nv_ptr <= ptr_next;
            if (last_slot) begin
              state <= S_IDLE;
              busy_o <= 1'b0;
            end else begin
              slot <= slot + 7'h1;
              state <= S_LOAD;
            end
          end
        end
        S_IDLE: begin
          if (clr_pend) begin
            state <= S_CISS;
            slot <= 7'h0;
            nv_ptr <= 7'h0;
            busy_o <= 1'b1;
          end else if (crit_pend) begin
            nv_req_o <= 1'b1;
            nv_we_o <= 1'b1;
            nv_addr_o <= nv_ptr;
            nv_wdata_o <= {1'b1, crit_rec};
            state <= S_WWAIT;
          end
        end
        S_WWAIT: begin
          if (nv_ack_i) begin
            nv_req_o <= 1'b0;
            nv_ptr <= ptr_next;
            state <= S_IDLE;
          end
        end
        S_CISS: begin
          nv_req_o <= 1'b1;
          nv_we_o <= 1'b1;
          nv_addr_o <= slot;
          nv_wdata_o <= 57'h0;
          state <= S_CWAIT;
        end
        S_CWAIT: begin
          if (nv_ack_i) begin
            nv_req_o <= 1'b0;
            if (last_slot) begin
              state <= S_IDLE;
              busy_o <= 1'b0;
            end else begin
              slot <= slot + 7'h1;
              state <= S_CISS;
            end
          end
        end
        default: begin
          state <= S_IDLE;
          nv_req_o <= 1'b0;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RAM logs

  wire [55:0] gen_rd;
  wire [63:0] eth_rd;
  wire [7:0] gen_cnt;
  wire [7:0] eth_cnt;

  ehl_ring #(
    .DW(`EHL_GEN_W),
    .DEPTH(`EHL_GEN_MEM),
    .AW(`EHL_GEN_AW)
  ) u_gen_ring (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(clr_i),
    .lim_i(gen_lim),
    .wr_i(gen_wr),
    .wr_data_i(gen_wdata),
    .rd_i(rd_req_i),
    .rd_idx_i(rd_idx_i),
    .rd_data_o(gen_rd),
    .cnt_o(gen_cnt)
  );

  ehl_ring #(
    .DW(`EHL_ETH_W),
    .DEPTH(`EHL_ETH_MEM),
    .AW(`EHL_ETH_AW)
  ) u_eth_ring (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(clr_i),
    .lim_i(`EHL_ETH_DEPTH),
    .wr_i(eth_err_i),
    .wr_data_i({eth_code_i, eth_detail_i, op_time_o}),
    .rd_i(rd_req_i),
    .rd_idx_i(rd_idx_i),
    .rd_data_o(eth_rd),
    .cnt_o(eth_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read-out, served from RAM only

  reg rd_p1;
  reg eth_p1;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_p1 <= 1'b0;
      eth_p1 <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_status_o <= 16'h0;
      rd_detail_o <= 16'h0;
      rd_exc_detail_o <= 64'h0;
      rd_time_o <= 32'h0;
      rd_count_o <= 8'h0;
    end else begin
      rd_p1 <= rd_req_i;
      eth_p1 <= rd_eth_i;
      rd_valid_o <= rd_p1;
      if (rd_p1) begin
        if (eth_p1) begin
          rd_status_o <= eth_rd[63:48];
          rd_detail_o <= eth_rd[47:32];
          rd_exc_detail_o <= 64'h0;
          rd_time_o <= eth_rd[31:0];
          rd_count_o <= eth_cnt;
        end else begin
          rd_status_o <= gen_rd[55:40];
          rd_detail_o <= {8'h00, gen_rd[39:32]};
          rd_exc_detail_o <= {gen_rd[39:32], 56'h0};
          rd_time_o <= gen_rd[31:0];
          rd_count_o <= gen_cnt;
        end
      end
    end
  end

endmodule // ehl_logger

`default_nettype wire

//--- ehl_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ehl_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic supply_on_i,
  input wire logic ctl_reset_i,
  input wire logic rd_req_i,
  input wire logic rd_eth_i,
  input wire logic rd_valid_o,
  input wire logic [15:0] rd_detail_o,
  input wire logic [63:0] rd_exc_detail_o,
  input wire logic [7:0] rd_count_o,
  input wire logic nv_req_o,
  input wire logic nv_we_o,
  input wire logic [6:0] nv_addr_o,
  input wire logic [56:0] nv_wdata_o,
  input wire logic nv_ack_i,
  input wire logic busy_o,
  input wire logic [31:0] op_time_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_answer: assert property (rd_req_i |-> ##2 rd_valid_o)
    else $error("read not answered");
  a_answer_cause: assert property (rd_valid_o |-> $past(rd_req_i, 2))
    else $error("answer without read");
  a_time_step: assert property ($changed(op_time_o) |->
    op_time_o == $past(op_time_o) + 32'h1 || op_time_o == 32'h0)
    else $error("operating time jumped");
  a_time_zero: assert property (ctl_reset_i |-> ##[1:2] op_time_o == 32'h0)
    else $error("operating time not zeroed");
  a_time_hold: assert property ((!supply_on_i && !ctl_reset_i) [*4] |=> $stable(op_time_o))
    else $error("time advanced with supply off");
  a_exc_byte: assert property (rd_valid_o && !$past(rd_eth_i, 2) |->
    rd_exc_detail_o == {rd_detail_o[7:0], 56'h0})
    else $error("node byte not at detail index 7");
  a_eth_exc: assert property (rd_valid_o && $past(rd_eth_i, 2) |-> rd_exc_detail_o == 64'h0)
    else $error("adaptor record carries alarm detail");
  a_count_cap: assert property (rd_valid_o |->
    rd_count_o <= ($past(rd_eth_i, 2) ? 8'h40 : 8'h64))
    else $error("record count above depth");
  a_nv_hold: assert property (nv_req_o && !nv_ack_i |=>
    nv_req_o && $stable(nv_addr_o) && $stable(nv_wdata_o) && $stable(nv_we_o))
    else $error("store request changed before ack");
  a_nv_release: assert property (nv_req_o && nv_ack_i |=> !nv_req_o)
    else $error("store request held after ack");
  a_restore_start: assert property ($rose(rst_n_i) |->
    ##[1:3] (nv_req_o && !nv_we_o && nv_addr_o == 7'h00))
    else $error("restore did not start at slot 0");
  a_clear_zero: assert property (nv_req_o && nv_we_o && busy_o |-> !nv_wdata_o[56])
    else $error("clear wrote a valid record");
endmodule // ehl_chk
`default_nettype wire

//--- ehl_nv_model.sv
`timescale 1ns/1ps
`default_nettype none
module ehl_nv_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [6:0] addr_i,
  input wire logic [56:0] wdata_i,
  output logic ack_o,
  output logic [56:0] rdata_o
);
  logic [56:0] mem [0:99];
  int dly = 3;
  int cnt = 0;
  initial begin
    ack_o = 1'h0;
    rdata_o = 57'h0;
    foreach (mem[k]) mem[k] = 57'h0;
    mem[0] = {1'h1, 16'hA5C3, 8'h3C, 32'h0000_0007};
  end
  always @(posedge clk_i) begin
    ack_o <= 1'h0;
    rdata_o <= ~rdata_o; // Released data is inverted every cycle, so it can look like a valid record
    if (req_i && !ack_o) begin
      if (cnt < dly) begin
        cnt <= cnt + 1;
      end else begin
        cnt <= 0;
        ack_o <= 1'h1;
        if (we_i) begin
          mem[addr_i] <= wdata_i;
        end else begin
          rdata_o <= mem[addr_i];
        end
      end
    end
  end
endmodule // ehl_nv_model
`default_nettype wire

//--- ehl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic supply_on_i = 1'h0;
  logic variant_new_i = 1'h0;
  logic err_i = 1'h0;
  logic err_crit_i = 1'h0;
  logic eth_err_i = 1'h0;
  logic clr_i = 1'h0;
  logic ctl_reset_i = 1'h0;
  logic rd_req_i = 1'h0;
  logic rd_eth_i = 1'h0;
  logic [15:0] err_status_i = 16'h0, eth_code_i = 16'h0, eth_detail_i = 16'h0;
  logic [7:0] err_node_i = 8'h0;
  logic [6:0] rd_idx_i = 7'h0;
  logic rd_valid_o, nv_req_o, nv_we_o, nv_ack_i, busy_o;
  logic [15:0] rd_status_o, rd_detail_o;
  logic [63:0] rd_exc_detail_o;
  logic [31:0] rd_time_o, op_time_o;
  logic [7:0] rd_count_o;
  logic [6:0] nv_addr_o;
  logic [56:0] nv_wdata_o, nv_rdata_i;
  int failures = 0;
  int compares = 0;
  ehl_logger #(.TICK_CYC(64'hA)) ehl_logger_inst (.clk_i, .rst_n_i, .supply_on_i, .variant_new_i,
    .err_i, .err_status_i, .err_node_i, .err_crit_i, .eth_err_i, .eth_code_i, .eth_detail_i,
    .clr_i, .ctl_reset_i, .rd_req_i, .rd_eth_i, .rd_idx_i, .rd_valid_o, .rd_status_o,
    .rd_detail_o, .rd_exc_detail_o, .rd_time_o, .rd_count_o, .nv_req_o, .nv_we_o, .nv_addr_o,
    .nv_wdata_o, .nv_ack_i, .nv_rdata_i, .busy_o, .op_time_o);
  ehl_nv_model ehl_nv_model_inst (.clk_i, .req_i(nv_req_o), .we_i(nv_we_o), .addr_i(nv_addr_o),
    .wdata_i(nv_wdata_o), .ack_o(nv_ack_i), .rdata_o(nv_rdata_i));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 3000 && busy_o !== 1'h0; k++) @(posedge clk_i);
    if (busy_o !== 1'h0) begin
      failures++;
      $display("Error %0t: busy timeout", $time);
      test_done;
    end
  endtask
  task automatic power_up;
    rst_n_i <= 1'h0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    wait_idle;
  endtask
  task automatic rd(input logic e, input logic [6:0] i, input logic [15:0] s, input logic [15:0] d);
    rd_req_i <= 1'h1;
    rd_eth_i <= e;
    rd_idx_i <= i;
    @(posedge clk_i);
    rd_req_i <= 1'h0;
    @(posedge clk_i);
    #1;
    chk(rd_valid_o, 64'h1);
    chk(rd_status_o, s);
    chk(rd_detail_o, d);
    @(posedge clk_i);
  endtask
  task automatic t_restore;
    rd(1'h0, 7'h0, 16'hA5C3, 16'h003C);
    chk(rd_time_o, 64'h7);
    chk(rd_count_o, 64'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_time;
    supply_on_i <= 1'h1;
    repeat (100) @(posedge clk_i);
    supply_on_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    chk(op_time_o, 64'hA);
    err_i <= 1'h1;
    err_status_i <= 16'h00EE;
    err_node_i <= 8'h77;
    @(posedge clk_i);
    err_i <= 1'h0;
    rd(1'h0, 7'h0, 16'h00EE, 16'h0077);
    chk(rd_time_o, 64'hA);
    chk(rd_exc_detail_o, {8'h77, 56'h0});
    chk(rd_count_o, 64'h2);
    ctl_reset_i <= 1'h1;
    @(posedge clk_i);
    ctl_reset_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    chk(op_time_o, 64'h0);
  endtask
  task automatic t_wrap;
    for (int i = 1; i <= 21; i++) begin
      err_i <= 1'h1;
      err_status_i <= 16'(i);
      err_node_i <= 8'(i);
      err_crit_i <= (i == 21);
      @(posedge clk_i);
    end
    err_i <= 1'h0;
    err_crit_i <= 1'h0;
    for (int k = 0; k < 200 && ehl_nv_model_inst.mem[1][56] !== 1'h1; k++) @(posedge clk_i);
    if (ehl_nv_model_inst.mem[1][56] !== 1'h1) begin
      failures++;
      $display("Error %0t: store write timeout", $time);
      test_done;
    end
    chk(ehl_nv_model_inst.mem[1], {1'h1, 16'h0015, 8'h15, 32'h0});
    rd(1'h0, 7'h0, 16'h0015, 16'h0015);
    chk(rd_time_o, 64'h0);
    chk(rd_count_o, 64'h14);
    rd(1'h0, 7'h13, 16'h0002, 16'h0002);
  endtask
  task automatic t_new;
    ehl_nv_model_inst.dly = 0;
    variant_new_i <= 1'h1;
    power_up;
    rd(1'h0, 7'h0, 16'h0015, 16'h0015);
    chk(rd_count_o, 64'h2);
    rd(1'h0, 7'h1, 16'hA5C3, 16'h003C);
    for (int i = 1; i <= 101; i++) begin
      err_i <= 1'h1;
      err_status_i <= 16'(i);
      err_node_i <= 8'(i);
      @(posedge clk_i);
    end
    err_i <= 1'h0;
    rd(1'h0, 7'h63, 16'h0002, 16'h0002);
    chk(rd_count_o, 64'h64);
  endtask
  task automatic t_eth;
    for (int i = 1; i <= 65; i++) begin
      eth_err_i <= 1'h1;
      eth_code_i <= 16'(i);
      eth_detail_i <= 16'(i + 256);
      @(posedge clk_i);
    end
    eth_err_i <= 1'h0;
    rd(1'h1, 7'h0, 16'h0041, 16'h0141);
    chk(rd_count_o, 64'h40);
    rd(1'h1, 7'h3F, 16'h0002, 16'h0102);
  endtask
  task automatic t_clear;
    clr_i <= 1'h1;
    @(posedge clk_i);
    clr_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    wait_idle;
    rd(1'h0, 7'h0, 16'h0, 16'h0);
    chk(rd_count_o, 64'h0);
    rd(1'h1, 7'h0, 16'h0, 16'h0);
    chk({ehl_nv_model_inst.mem[0][56], ehl_nv_model_inst.mem[1][56]}, 64'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    power_up;
    t_restore;
    t_time;
    t_wrap;
    t_new;
    t_eth;
    t_clear;
    test_done;
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    failures++;
    $display("Error %0t: run timeout", $time);
    test_done;
  end
endmodule // testbench
bind ehl_logger ehl_chk ehl_chk_inst (.clk_i, .rst_n_i, .supply_on_i, .ctl_reset_i, .rd_req_i,
  .rd_eth_i, .rd_valid_o, .rd_detail_o, .rd_exc_detail_o, .rd_count_o, .nv_req_o, .nv_we_o,
  .nv_addr_o, .nv_wdata_o, .nv_ack_i, .busy_o, .op_time_o);
`default_nettype wire
